// [verilog/far_regs.svh]
`ifndef FAR_REGS_SVH
`define FAR_REGS_SVH

`define FAR_CLK_MHZ         100
`define FAR_TICK_MS         100
`define FAR_TICK_CYCLES     (`FAR_TICK_MS * 1000 * `FAR_CLK_MHZ)

`define FAR_OFS_CTRL        12'h000
`define FAR_OFS_WINDOW      12'h004
`define FAR_OFS_DELAY       12'h008
`define FAR_OFS_STATUS      12'h00C
`define FAR_OFS_IRQ_STAT    12'h010
`define FAR_OFS_IRQ_MASK    12'h014
`define FAR_OFS_W1_SEL      12'h018
`define FAR_OFS_W1_LOW      12'h01C
`define FAR_OFS_W1_HIGH     12'h020
`define FAR_OFS_W2_SEL      12'h024
`define FAR_OFS_W2_LOW      12'h028
`define FAR_OFS_W2_HIGH     12'h02C
`define FAR_OFS_RELAY       12'h030
`define FAR_OFS_FW_REV      12'h034
`define FAR_OFS_TEST_DATE   12'h038

`define FAR_CTRL_COUNT_LSB  0
`define FAR_CTRL_AC_LSB     8
`define FAR_RST_CTRL        32'h0000_0F03
`define FAR_RST_WINDOW      16'h012C
`define FAR_RST_DELAY       16'h0003
`define FAR_RST_RELAY       6'h00

`define FAR_RELAY_NONE      3'h0
`define FAR_RELAY_W1_ABOVE  3'h1
`define FAR_RELAY_W1_BELOW  3'h2
`define FAR_RELAY_W2_ABOVE  3'h3
`define FAR_RELAY_W2_BELOW  3'h4

`define FAR_IRQ_AUTO        0
`define FAR_IRQ_LOCK        1
`define FAR_IRQ_W1          2
`define FAR_IRQ_W2          3
`define FAR_IRQ_FAULT       4

`define FAR_FW_REV_VAL      32'h0000_0100
`define FAR_TEST_DATE_VAL   16'h0000

`endif

// [verilog/far_pkg.sv]
package far_pkg;

  typedef enum logic [2:0] {
    FAR_IDLE = 3'b001,
    FAR_WAIT = 3'b010,
    FAR_LOCK = 3'b100
  } far_state_t;

  typedef logic [15:0] far_value_t;

endpackage

// [verilog/far_watch.sv]
`timescale 1ns/1ns
module far_watch (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire far_pkg::far_value_t value,
  input  wire far_pkg::far_value_t low_limit,
  input  wire far_pkg::far_value_t high_limit,
  output logic                   above_q,
  output logic                   below_q
);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      above_q <= 1'b0;
    end else if (value > high_limit) begin
      above_q <= 1'b1;
    end else if (value < low_limit) begin
      above_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      below_q <= 1'b0;
    end else if (value < low_limit) begin
      below_q <= 1'b1;
    end else if (value > high_limit) begin
      below_q <= 1'b0;
    end
  end

endmodule

// [verilog/far_core.sv]
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/1ns
`include "far_regs.svh"
module far_core #(
  parameter int unsigned TICK_CYCLES = `FAR_TICK_CYCLES,
  parameter logic [15:0] TEST_DATE   = `FAR_TEST_DATE_VAL
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic          fault_overcurrent,
  input  wire logic          fault_bus_high,
  input  wire logic          fault_bus_low,
  input  wire logic          fault_input_loss,
  input  wire logic          panel_reset_pin,
  input  wire logic          manual_clear_pin,
  input  wire logic [255:0]  op_data,
  output logic               drive_stopped,
  output logic               reset_locked,
  output logic               relay1_out,
  output logic               relay2_out,
  output logic               irq
);

  localparam int SLOTS = 8;
  localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);

  logic [31:0] ctrl_q;
  logic [15:0] window_q;
  logic [15:0] delay_q;
  logic [4:0]  irq_stat_q;
  logic [4:0]  irq_mask_q;
  logic [3:0]  w1_sel_q;
  logic [3:0]  w2_sel_q;
  logic [15:0] w1_low_q;
  logic [15:0] w1_high_q;
  logic [15:0] w2_low_q;
  logic [15:0] w2_high_q;
  logic [5:0]  relay_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;
  logic [3:0]  fault_q;
  logic [31:0] tick_cnt_q;
  logic        tick;
  logic [15:0] now_q;
  logic [15:0] delay_cnt_q;
  logic [2:0]  wr_ptr_q;
  logic [SLOTS-1:0] slot_vld_q;
  logic [15:0] slot_ts_q [SLOTS];
  logic [3:0]  recent_cnt;
  logic        panel_s1_q;
  logic        panel_s2_q;
  logic        clear_s1_q;
  logic        clear_s2_q;
  logic        manual_prev_q;
  logic        manual_rst;
  logic        do_auto;
  logic        go_lock;
  logic        w1_above;
  logic        w1_below;
  logic        w2_above;
  logic        w2_below;
  logic        w1_prev_q;
  logic        w2_prev_q;
  far_pkg::far_state_t state_q;
  far_pkg::far_state_t state_d;

  wire        wr_en    = psel && penable && pwrite;
  wire        rd_setup = psel && !penable;
  wire [3:0]  allowed  = ctrl_q[`FAR_CTRL_COUNT_LSB +: 4];
  wire [3:0]  ac_en    = ctrl_q[`FAR_CTRL_AC_LSB +: 4];
  wire [3:0]  fault_in = {fault_input_loss, fault_bus_low, fault_bus_high, fault_overcurrent};
  wire        has_fault = |fault_q;
  wire        all_auto = (fault_q & ~ac_en) == 4'h0;
  wire        budget   = recent_cnt < allowed;
  wire        delay_done = tick && ((delay_cnt_q + 16'h0001) >= delay_q);

  // Panel and external clear pins pass a two-stage synchroniser.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      panel_s1_q <= 1'b0;
      panel_s2_q <= 1'b0;
      clear_s1_q <= 1'b0;
      clear_s2_q <= 1'b0;
    end else begin
      panel_s1_q <= panel_reset_pin;
      panel_s2_q <= panel_s1_q;
      clear_s1_q <= manual_clear_pin;
      clear_s2_q <= clear_s1_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      manual_prev_q <= 1'b0;
    end else begin
      manual_prev_q <= panel_s2_q || clear_s2_q;
    end
  end

  assign manual_rst = (panel_s2_q || clear_s2_q) && !manual_prev_q;

  // Time base: one enable pulse per tick of the window and delay counters.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_q <= 32'h0000_0000;
    end else if (tick) begin
      tick_cnt_q <= 32'h0000_0000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
    end
  end
  assign tick = tick_cnt_q == TICK_LAST;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      now_q <= 16'h0000;
    end else if (tick) begin
      now_q <= now_q + 16'h0001;
    end
  end

  // Fault latches; a new fault wins over a clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_q <= 4'h0;
    end else if (manual_rst) begin
      fault_q <= fault_in;
    end else if (do_auto) begin
      fault_q <= (fault_q & ~ac_en) | fault_in;
    end else begin
      fault_q <= fault_q | fault_in;
    end
  end

  always_comb begin
    recent_cnt = 4'h0;
    for (int i = 0; i < SLOTS; i++) begin
      recent_cnt = recent_cnt + {3'h0, slot_vld_q[i]};
    end
  end

  for (genvar g = 0; g < SLOTS; g++) begin : g_slot
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        slot_vld_q[g] <= 1'b0;
        slot_ts_q[g]  <= 16'h0000;
      end else if (do_auto && (wr_ptr_q == 3'(g))) begin
        slot_vld_q[g] <= 1'b1;
        slot_ts_q[g]  <= now_q;
      end else if (tick && ((now_q + 16'h0001 - slot_ts_q[g]) >= window_q)) begin
        slot_vld_q[g] <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_q <= 3'h0;
    end else if (do_auto) begin
      wr_ptr_q <= wr_ptr_q + 3'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      delay_cnt_q <= 16'h0000;
    end else if (state_q != far_pkg::FAR_WAIT) begin
      delay_cnt_q <= 16'h0000;
    end else if (tick) begin
      delay_cnt_q <= delay_cnt_q + 16'h0001;
    end
  end

  // Auto reset sequencer.
  always_comb begin
    state_d = state_q;
    do_auto = 1'b0;
    go_lock = 1'b0;
    unique case (state_q)
      far_pkg::FAR_IDLE: begin
        if (has_fault && all_auto && !manual_rst) begin
          if (!budget) begin
            state_d = far_pkg::FAR_LOCK;
            go_lock = 1'b1;
          end else if (delay_q == 16'h0000) begin
            do_auto = 1'b1;
          end else begin
            state_d = far_pkg::FAR_WAIT;
          end
        end
      end
      far_pkg::FAR_WAIT: begin
        if (manual_rst || !all_auto || !has_fault) begin
          state_d = far_pkg::FAR_IDLE;
        end else if (delay_done) begin
          do_auto = 1'b1;
          state_d = far_pkg::FAR_IDLE;
        end
      end
      far_pkg::FAR_LOCK: begin
        if (manual_rst) begin
          state_d = far_pkg::FAR_IDLE;
        end
      end
      default: begin
        state_d = far_pkg::FAR_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= far_pkg::FAR_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  assign drive_stopped = has_fault || (state_q == far_pkg::FAR_LOCK);
  assign reset_locked  = state_q == far_pkg::FAR_LOCK;

  far_watch u_watch1 (
    .pclk       (pclk),
    .presetn    (presetn),
    .value      (op_data[{w1_sel_q, 4'h0} +: 16]),
    .low_limit  (w1_low_q),
    .high_limit (w1_high_q),
    .above_q    (w1_above),
    .below_q    (w1_below)
  );

  far_watch u_watch2 (
    .pclk       (pclk),
    .presetn    (presetn),
    .value      (op_data[{w2_sel_q, 4'h0} +: 16]),
    .low_limit  (w2_low_q),
    .high_limit (w2_high_q),
    .above_q    (w2_above),
    .below_q    (w2_below)
  );

  function automatic logic relay_pick(input logic [2:0] fn, input logic a1, input logic b1,
                                      input logic a2, input logic b2);
    logic r;
    r = 1'b0;
    case (fn)
      `FAR_RELAY_W1_ABOVE: r = a1;
      `FAR_RELAY_W1_BELOW: r = b1;
      `FAR_RELAY_W2_ABOVE: r = a2;
      `FAR_RELAY_W2_BELOW: r = b2;
      default:             r = 1'b0;
    endcase
    return r;
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      relay1_out <= 1'b0;
      relay2_out <= 1'b0;
    end else begin
      relay1_out <= relay_pick(relay_q[2:0], w1_above, w1_below, w2_above, w2_below);
      relay2_out <= relay_pick(relay_q[5:3], w1_above, w1_below, w2_above, w2_below);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      w1_prev_q <= 1'b0;
      w2_prev_q <= 1'b0;
    end else begin
      w1_prev_q <= w1_above || w1_below;
      w2_prev_q <= w2_above || w2_below;
    end
  end

  // Sticky event bits; a set wins over a write-one clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= 5'h00;
    end else begin
      irq_stat_q <= (irq_stat_q & ~((wr_en && paddr == `FAR_OFS_IRQ_STAT) ? pwdata[4:0] : 5'h00))
                  | {|(fault_in & ~fault_q),
                     (w2_above || w2_below) != w2_prev_q,
                     (w1_above || w1_below) != w1_prev_q,
                     go_lock, do_auto};
    end
  end
  assign irq = |(irq_stat_q & irq_mask_q);

  // Software-written configuration registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q     <= `FAR_RST_CTRL;
      window_q   <= `FAR_RST_WINDOW;
      delay_q    <= `FAR_RST_DELAY;
      irq_mask_q <= 5'h00;
      w1_sel_q   <= 4'h0;
      w2_sel_q   <= 4'h0;
      w1_low_q   <= 16'h0000;
      w1_high_q  <= 16'hFFFF;
      w2_low_q   <= 16'h0000;
      w2_high_q  <= 16'hFFFF;
      relay_q    <= `FAR_RST_RELAY;
    end else if (wr_en) begin
      case (paddr)
        `FAR_OFS_CTRL:     ctrl_q     <= {20'h00000, pwdata[11:8], 4'h0, pwdata[3:0]};
        `FAR_OFS_WINDOW:   window_q   <= pwdata[15:0];
        `FAR_OFS_DELAY:    delay_q    <= pwdata[15:0];
        `FAR_OFS_IRQ_MASK: irq_mask_q <= pwdata[4:0];
        `FAR_OFS_W1_SEL:   w1_sel_q   <= pwdata[3:0];
        `FAR_OFS_W1_LOW:   w1_low_q   <= pwdata[15:0];
        `FAR_OFS_W1_HIGH:  w1_high_q  <= pwdata[15:0];
        `FAR_OFS_W2_SEL:   w2_sel_q   <= pwdata[3:0];
        `FAR_OFS_W2_LOW:   w2_low_q   <= pwdata[15:0];
        `FAR_OFS_W2_HIGH:  w2_high_q  <= pwdata[15:0];
        `FAR_OFS_RELAY:    relay_q    <= pwdata[5:0];
        default: ;
      endcase
    end
  end

  // Read data and error are captured in the setup cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (rd_setup) begin
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      case (paddr)
        `FAR_OFS_CTRL:      prdata_q <= ctrl_q;
        `FAR_OFS_WINDOW:    prdata_q <= {16'h0000, window_q};
        `FAR_OFS_DELAY:     prdata_q <= {16'h0000, delay_q};
        `FAR_OFS_STATUS:    prdata_q <= {16'h0000, recent_cnt, 1'b0, state_q, 4'h0, fault_q};
        `FAR_OFS_IRQ_STAT:  prdata_q <= {27'h0000000, irq_stat_q};
        `FAR_OFS_IRQ_MASK:  prdata_q <= {27'h0000000, irq_mask_q};
        `FAR_OFS_W1_SEL:    prdata_q <= {28'h0000000, w1_sel_q};
        `FAR_OFS_W1_LOW:    prdata_q <= {16'h0000, w1_low_q};
        `FAR_OFS_W1_HIGH:   prdata_q <= {16'h0000, w1_high_q};
        `FAR_OFS_W2_SEL:    prdata_q <= {28'h0000000, w2_sel_q};
        `FAR_OFS_W2_LOW:    prdata_q <= {16'h0000, w2_low_q};
        `FAR_OFS_W2_HIGH:   prdata_q <= {16'h0000, w2_high_q};
        `FAR_OFS_RELAY:     prdata_q <= {26'h0000000, relay_q};
        `FAR_OFS_FW_REV:    prdata_q <= `FAR_FW_REV_VAL;
        `FAR_OFS_TEST_DATE: prdata_q <= {16'h0000, TEST_DATE};
        default:            pslverr_q <= 1'b1;
      endcase
    end
  end

  assign prdata  = prdata_q;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && pslverr_q;

endmodule

// [tb/far_core_chk.sv]
`timescale 1ns/1ns
module far_core_chk (
  input wire logic         pclk,
  input wire logic         presetn,
  input wire logic         psel,
  input wire logic         penable,
  input wire logic         pready,
  input wire logic         pslverr,
  input wire logic         fault_overcurrent,
  input wire logic         fault_bus_high,
  input wire logic         fault_bus_low,
  input wire logic         fault_input_loss,
  input wire logic         panel_reset_pin,
  input wire logic         manual_clear_pin,
  input wire logic [255:0] op_data,
  input wire logic         drive_stopped,
  input wire logic         reset_locked,
  input wire logic         relay1_out,
  input wire logic         relay2_out
);
  logic any_f;
  logic man;
  assign any_f = fault_overcurrent | fault_bus_high | fault_bus_low | fault_input_loss;
  assign man = panel_reset_pin | manual_clear_pin;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_ready; psel && penable |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("access without ready");
  property p_err; pslverr |-> psel && penable; endproperty
  a_err: assert property (p_err) else $error("error outside access");
  property p_stop; $rose(any_f) |=> drive_stopped; endproperty
  a_stop: assert property (p_stop) else $error("fault did not stop drive");
  property p_lkstop; reset_locked |-> drive_stopped; endproperty
  a_lkstop: assert property (p_lkstop) else $error("locked but running");
  property p_lkin; $rose(reset_locked) |-> $past(drive_stopped); endproperty
  a_lkin: assert property (p_lkin) else $error("lock without fault");
  property p_lkout; $fell(reset_locked) |-> $past(man, 2) || $past(man, 3) || $past(man, 4); endproperty
  a_lkout: assert property (p_lkout) else $error("lock left without manual");
  property p_r1; (!psel && $stable(op_data)) [*5] |-> $stable(relay1_out); endproperty
  a_r1: assert property (p_r1) else $error("relay1 moved alone");
  property p_r2; (!psel && $stable(op_data)) [*5] |-> $stable(relay2_out); endproperty
  a_r2: assert property (p_r2) else $error("relay2 moved alone");
  c_lock: cover property ($rose(reset_locked));
  c_free: cover property ($fell(reset_locked));
  c_relay: cover property ($rose(relay1_out));
endmodule
bind far_core far_core_chk u_chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr, .fault_overcurrent,
  .fault_bus_high, .fault_bus_low, .fault_input_loss, .panel_reset_pin, .manual_clear_pin, .op_data,
  .drive_stopped, .reset_locked, .relay1_out, .relay2_out);

// [tb/far_panel.sv]
`timescale 1ns/1ns
module far_panel (
  input  wire logic        pclk,
  input  wire logic        relay1_out,
  input  wire logic        relay2_out,
  input  wire logic        req_valid,
  input  wire logic [1:0]  req_kind,
  input  wire logic [3:0]  req_idx,
  input  wire logic [15:0] req_val,
  output logic             fault_overcurrent,
  output logic             fault_bus_high,
  output logic             fault_bus_low,
  output logic             fault_input_loss,
  output logic             panel_reset_pin,
  output logic             manual_clear_pin,
  output logic [255:0]     op_data
);
  logic [3:0] src;
  logic [2:0] hold;
  logic       from_panel;
  assign {fault_input_loss, fault_bus_low, fault_bus_high, fault_overcurrent} = src;
  assign panel_reset_pin  = (hold != 3'h0) && from_panel;
  assign manual_clear_pin = (hold != 3'h0) && !from_panel;
  initial begin
    src = 4'h0;
    hold = 3'h0;
    from_panel = 1'h0;
    op_data = '0;
  end
  // Request kinds: 0 fault pulse, 1 panel press, 2 remote clear press, 3 quantity update.
  // Sources pulse one cycle.
  always @(posedge pclk) begin
    src <= (req_valid && req_kind == 2'h0) ? (4'h1 << req_idx[1:0]) : 4'h0;
  end
  always @(posedge pclk) begin
    if (req_valid && (req_kind == 2'h1 || req_kind == 2'h2)) begin
      hold <= 3'h6;
      from_panel <= req_kind == 2'h1;
    end else if (hold != 3'h0) begin
      hold <= hold - 3'h1;
    end
  end
  always @(posedge pclk) begin
    if (req_valid && req_kind == 2'h3) begin
      op_data[16*req_idx +: 16] <= req_val;
    end
  end
endmodule

// [tb/tb_fault_autoreset_and_supervision.sv]
`timescale 1ns/1ns
`include "far_regs.svh"
module tb_fault_autoreset_and_supervision;
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata;
  logic         fault_overcurrent, fault_bus_high, fault_bus_low, fault_input_loss;
  logic         panel_reset_pin, manual_clear_pin, drive_stopped, reset_locked, relay1_out, relay2_out;
  logic [255:0] op_data;
  logic         req_valid;
  logic [1:0]   req_kind;
  logic [3:0]   req_idx;
  logic [15:0]  req_val;
  int           err_total;
  int           comparisons;
  far_core #(.TICK_CYCLES(10)) DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .fault_overcurrent, .fault_bus_high, .fault_bus_low, .fault_input_loss,
    .panel_reset_pin, .manual_clear_pin, .op_data, .drive_stopped, .reset_locked, .relay1_out,
    .relay2_out, .irq);
  far_panel u_far (.pclk, .relay1_out, .relay2_out, .req_valid, .req_kind, .req_idx, .req_val,
    .fault_overcurrent, .fault_bus_high, .fault_bus_low, .fault_input_loss, .panel_reset_pin,
    .manual_clear_pin, .op_data);
  initial begin
    pclk = 1'h0;
    forever #5 pclk = ~pclk;
  end
  task automatic conclude();
    $display("mismatches %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    comparisons++;
    if (s !== x) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, x, s);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
    #1;
  endtask
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1) begin
      err_total++;
      conclude();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    xfer(a, 1'h1, d, r, e);
  endtask
  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    xfer(a, 1'h0, 32'h0, r, e);
    chk(nm, r, x);
  endtask
  task automatic waitlow(output int n);
    n = 0;
    while (drive_stopped !== 1'h0) begin
      cyc(1);
      n++;
      if (n > 300) begin
        err_total++;
        conclude();
      end
    end
  endtask
  task automatic ask(input logic [1:0] k, input logic [3:0] i, input logic [15:0] v);
    @(posedge pclk);
    req_valid <= 1'h1;
    req_kind <= k;
    req_idx <= i;
    req_val <= v;
    @(posedge pclk);
    req_valid <= 1'h0;
  endtask
  task automatic trip(input logic [3:0] i);
    ask(2'h0, i, 16'h0000);
    cyc(1);
  endtask
  task automatic press(input logic pnl);
    ask(pnl ? 2'h1 : 2'h2, 4'h0, 16'h0000);
  endtask
  task automatic set_q(input logic [3:0] n, input logic [15:0] v);
    ask(2'h3, n, v);
  endtask
  task automatic s_regs();
    logic [31:0] r;
    logic e;
    rd("ctrl", `FAR_OFS_CTRL, 32'h0000_0F03);
    rd("window", `FAR_OFS_WINDOW, 32'h0000_012C);
    rd("delay", `FAR_OFS_DELAY, 32'h0000_0003);
    wr(`FAR_OFS_FW_REV, 32'hFFFF_FFFF);
    rd("fw", `FAR_OFS_FW_REV, 32'h0000_0100);
    rd("date", `FAR_OFS_TEST_DATE, 32'h0000_0000);
    xfer(12'h040, 1'h0, 32'h0, r, e);
    chk("unmapped", e, 32'h1);
  endtask
  task automatic s_now();
    wr(`FAR_OFS_DELAY, 32'h0);
    wr(`FAR_OFS_IRQ_MASK, 32'h1);
    trip(4'h0);
    cyc(3);
    chk("stop_oc", drive_stopped, 32'h0);
    rd("stat_oc", `FAR_OFS_STATUS, 32'h0000_1100);
    chk("irq_on", irq, 32'h1);
    wr(`FAR_OFS_IRQ_STAT, 32'h1F);
    cyc(1);
    chk("irq_off", irq, 32'h0);
  endtask
  task automatic s_wait();
    int n;
    wr(`FAR_OFS_DELAY, 32'h2);
    trip(4'h1);
    waitlow(n);
    chk("wait_len", n >= 9 && n <= 40, 32'h1);
    rd("stat_bh", `FAR_OFS_STATUS, 32'h0000_2100);
  endtask
  task automatic s_manual();
    int n;
    wr(`FAR_OFS_CTRL, 32'h0000_0B03);
    trip(4'h2);
    cyc(50);
    rd("stat_bl", `FAR_OFS_STATUS, 32'h0000_2104);
    press(1'h1);
    waitlow(n);
    wr(`FAR_OFS_DELAY, 32'h0);
    trip(4'h3);
    cyc(3);
    rd("stat_il", `FAR_OFS_STATUS, 32'h0000_3100);
  endtask
  task automatic s_lock();
    int n;
    wr(`FAR_OFS_WINDOW, 32'h0);
    cyc(30);
    rd("aged", `FAR_OFS_STATUS, 32'h0000_0100);
    wr(`FAR_OFS_WINDOW, 32'h100);
    wr(`FAR_OFS_CTRL, 32'h0000_0F02);
    for (int i = 0; i < 3; i++) begin
      trip(4'h0);
      cyc(4);
    end
    chk("locked", reset_locked, 32'h1);
    cyc(40);
    chk("held", drive_stopped, 32'h1);
    press(1'h0);
    waitlow(n);
    chk("freed", reset_locked, 32'h0);
    wr(`FAR_OFS_WINDOW, 32'h2);
    cyc(50);
    rd("slid", `FAR_OFS_STATUS, 32'h0000_0100);
  endtask
  task automatic step(input logic [15:0] a, input logic [15:0] b, input logic [1:0] x);
    set_q(4'h2, a);
    set_q(4'h5, b);
    cyc(4);
    chk("relays", {relay2_out, relay1_out}, x);
  endtask
  task automatic s_watch();
    wr(`FAR_OFS_W1_SEL, 32'h2);
    wr(`FAR_OFS_W1_LOW, 32'h64);
    wr(`FAR_OFS_W1_HIGH, 32'hC8);
    wr(`FAR_OFS_W2_SEL, 32'h5);
    wr(`FAR_OFS_W2_LOW, 32'h50);
    wr(`FAR_OFS_W2_HIGH, 32'h60);
    wr(`FAR_OFS_RELAY, 32'h21);
    step(16'h0096, 16'h0070, 2'h0);
    step(16'h00FA, 16'h0040, 2'h3);
    step(16'h0096, 16'h0058, 2'h3);
    step(16'h0032, 16'h0070, 2'h0);
    wr(`FAR_OFS_RELAY, 32'h1A);
    cyc(4);
    chk("swap", {relay2_out, relay1_out}, 32'h3);
  endtask
  initial begin
    err_total = 0;
    comparisons = 0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {req_valid, req_kind, req_idx, req_val} = '0;
    presetn = 1'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    s_regs();
    s_now();
    s_wait();
    s_manual();
    s_lock();
    s_watch();
    conclude();
  end
endmodule
